// *** pkg/qps_pkg.sv ***
`default_nettype none
package qps_pkg;
   localparam int QNUM = 4;
   localparam int QW = 2;
   localparam int DEPTH = 8;
   localparam int PTR_W = 3;
   localparam int CNT_W = 4;
   localparam int FRAME_W = 8;
   localparam int PORTS = 8;
   localparam int PORT_W = 3;
   localparam int PRIO_W = 3;
   localparam int SEQ_W = 6;
   localparam int WGT_W = 8;
   localparam int PCFG_W = 4;
   localparam int MAP_W = 16;

   // queue index: 0 highest, 1 second_high_queue, 2 second_low_queue, 3 lowest
   localparam logic [QW-1:0] Q_HIGHEST = 2'h0;
   localparam logic [QW-1:0] Q_LOWEST = 2'h3;

   // scheduling mode encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_FCFS = 2'h1;
   localparam logic [1:0] MODE_STRICT = 2'h2;
   localparam logic [1:0] MODE_WRR = 2'h3;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WEIGHT = 8'h04;
   localparam logic [7:0] ADDR_MAP = 8'h08;
   localparam logic [7:0] ADDR_PORT_PRIO = 8'h0C;
   localparam logic [7:0] ADDR_PORT_SET = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // field positions
   localparam int PSET_MASK_LSB = 8;
   localparam int PSET_EN_BIT = 4;
   localparam int PCFG_EN_BIT = 3;

   // values after reset
   localparam logic [1:0] RST_MODE = MODE_WRR;
   localparam logic [31:0] RST_WEIGHT = 32'h0102_0408;
   localparam logic [MAP_W-1:0] RST_MAP = 16'h05AF;
   localparam logic [31:0] RST_PORT_PRIO = 32'h0000_0000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

// *** logic/qps_top.sv ***
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module qps_top (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic hsel_i, // ahb slave select
   input wire logic [31:0] haddr_i, // ahb address
   input wire logic [1:0] htrans_i, // ahb transfer type
   input wire logic hwrite_i, // ahb write
   input wire logic [2:0] hsize_i, // ahb size
   input wire logic [31:0] hwdata_i, // ahb write data
   input wire logic hready_i, // ahb bus ready
   output logic hreadyout_o, // ahb slave ready
   output logic hresp_o, // ahb response
   output logic [31:0] hrdata_o, // ahb read data
   input wire logic rx_valid_i, // frame descriptor offered
   output logic rx_ready_o, // descriptor accepted this cycle
   input wire logic [qps_pkg::FRAME_W-1:0] rx_frame_i, // frame handle
   input wire logic [qps_pkg::PORT_W-1:0] rx_port_i, // receive port
   input wire logic rx_tagged_i, // frame carries priority tag
   input wire logic [qps_pkg::PRIO_W-1:0] rx_pcp_i, // tag priority
   output logic tx_valid_o, // frame descriptor ready to send
   input wire logic tx_ready_i, // transmit side takes it
   output logic [qps_pkg::FRAME_W-1:0] tx_frame_o, // frame handle
   output logic [qps_pkg::QW-1:0] tx_queue_o // queue it left from
);
   import qps_pkg::*;

   function automatic logic [WGT_W-1:0] weight_of(input logic [31:0] w, input logic [QW-1:0] q);
      logic [WGT_W-1:0] v;
      v = w[q*WGT_W +: WGT_W];
      // a zero weight still lets one frame through
      weight_of = (v == '0) ? 8'h01 : v;
   endfunction

   function automatic logic [PCFG_W-1:0] port_cfg(input logic [31:0] p, input logic [PORT_W-1:0] n);
      port_cfg = p[n*PCFG_W +: PCFG_W];
   endfunction

   logic [1:0] mode_ff;
   logic [31:0] weight_ff;
   logic [MAP_W-1:0] map_ff;
   logic [31:0] port_prio_ff;
   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic rx_ready_ff;
   logic [SEQ_W-1:0] seq_ff;
   logic [QW-1:0] cur_ff;
   logic [WGT_W-1:0] wcnt_ff;
   logic v0_ff;
   logic v1_ff;
   logic [FRAME_W-1:0] d0_ff;
   logic [FRAME_W-1:0] d1_ff;
   logic [QW-1:0] q0_ff;
   logic [QW-1:0] q1_ff;

   logic [FRAME_W-1:0] head_frame [QNUM];
   logic [SEQ_W-1:0] head_seq [QNUM];
   logic [CNT_W-1:0] q_cnt [QNUM];
   logic [CNT_W-1:0] nxt_cnt [QNUM];
   logic [QNUM-1:0] q_busy;

   logic [PRIO_W-1:0] rx_prio;
   logic [QW-1:0] rx_queue;
   logic [PCFG_W-1:0] rx_pcfg;
   logic rx_push;
   logic [QW-1:0] pick;
   logic pick_ok;
   logic pop_en;
   logic out_pop;
   logic ap_ok;
   logic [31:0] rd_mux;
   logic [WGT_W-1:0] nxt_wcnt;

   // classification
   always_comb
   begin
      rx_pcfg = port_cfg(port_prio_ff, rx_port_i);
      if (rx_tagged_i)
      begin
         rx_prio = rx_pcp_i;
      end
      else if (rx_pcfg[PCFG_EN_BIT])
      begin
         rx_prio = rx_pcfg[PRIO_W-1:0];
      end
      else
      begin
         rx_prio = '0;
      end
      rx_queue = map_ff[rx_prio*QW +: QW];
   end

   assign rx_push = rx_valid_i && rx_ready_ff;

   // per-queue storage
   genvar g;
   generate
      for (g = 0; g < QNUM; g++)
      begin : g_q
         logic [FRAME_W-1:0] fmem [DEPTH];
         logic [SEQ_W-1:0] smem [DEPTH];
         logic [PTR_W-1:0] wr_ff;
         logic [PTR_W-1:0] rd_ff;
         logic [CNT_W-1:0] cnt_ff;
         logic push;
         logic pop;

         assign push = rx_push && (rx_queue == QW'(g));
         assign pop = pop_en && (pick == QW'(g));

         always_ff @(posedge clk_i)
         begin
            if (push)
            begin
               fmem[wr_ff] <= rx_frame_i;
               smem[wr_ff] <= seq_ff;
            end
         end

         always_comb
         begin
            nxt_cnt[g] = cnt_ff;
            if (push && !pop)
            begin
               nxt_cnt[g] = cnt_ff + 4'h1;
            end
            else if (pop && !push)
            begin
               nxt_cnt[g] = cnt_ff - 4'h1;
            end
         end

         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               wr_ff <= '0;
               rd_ff <= '0;
               cnt_ff <= '0;
            end
            else
            begin
               if (push)
               begin
                  wr_ff <= wr_ff + 3'h1;
               end
               if (pop)
               begin
                  rd_ff <= rd_ff + 3'h1;
               end
               cnt_ff <= nxt_cnt[g];
            end
         end

         assign head_frame[g] = fmem[rd_ff];
         assign head_seq[g] = smem[rd_ff];
         assign q_cnt[g] = cnt_ff;
         assign q_busy[g] = (cnt_ff != '0);
      end
   endgenerate

   // scheduler pick
   always_comb
   begin
      logic [SEQ_W-1:0] best_age;
      logic [SEQ_W-1:0] age;
      logic [QW-1:0] idx;
      logic found;
      best_age = '0;
      age = '0;
      idx = '0;
      found = 1'b0;
      pick = '0;
      case (mode_ff)
         MODE_STRICT:
         begin
            for (int i = QNUM - 1; i >= 0; i--)
            begin
               if (q_busy[i])
               begin
                  pick = QW'(i);
               end
            end
         end
         MODE_WRR:
         begin
            for (int i = 0; i < QNUM; i++)
            begin
               idx = cur_ff + QW'(i);
               if (!found && q_busy[idx])
               begin
                  pick = idx;
                  found = 1'b1;
               end
            end
         end
         default:
         begin
            // oldest head by arrival stamp; ages fit since total depth < 2**SEQ_W
            for (int i = 0; i < QNUM; i++)
            begin
               age = seq_ff - head_seq[i];
               if (q_busy[i] && age > best_age)
               begin
                  best_age = age;
                  pick = QW'(i);
               end
            end
         end
      endcase
   end

   assign pick_ok = |q_busy;
   assign pop_en = pick_ok && !v1_ff;
   assign out_pop = v0_ff && tx_ready_i;
   // frames already sent in this turn, counting the one popped now
   assign nxt_wcnt = (pick == cur_ff) ? (wcnt_ff + 8'h01) : 8'h01;

   // arrival stamp and input ready
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         seq_ff <= '0;
         rx_ready_ff <= 1'b0;
      end
      else
      begin
         if (rx_push)
         begin
            seq_ff <= seq_ff + 6'h01;
         end
         rx_ready_ff <= (nxt_cnt[0] < CNT_W'(DEPTH)) && (nxt_cnt[1] < CNT_W'(DEPTH)) &&
                        (nxt_cnt[2] < CNT_W'(DEPTH)) && (nxt_cnt[3] < CNT_W'(DEPTH));
      end
   end

   // weighted round robin position
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cur_ff <= Q_HIGHEST;
         wcnt_ff <= '0;
      end
      else if (mode_ff != MODE_WRR)
      begin
         cur_ff <= Q_HIGHEST;
         wcnt_ff <= '0;
      end
      else if (pop_en)
      begin
         if (nxt_wcnt >= weight_of(weight_ff, pick))
         begin
            cur_ff <= pick + 2'h1;
            wcnt_ff <= '0;
         end
         else
         begin
            cur_ff <= pick;
            wcnt_ff <= nxt_wcnt;
         end
      end
   end

   // two-entry output buffer
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         v0_ff <= 1'b0;
         v1_ff <= 1'b0;
         d0_ff <= '0;
         d1_ff <= '0;
         q0_ff <= '0;
         q1_ff <= '0;
      end
      else
      begin
         if (out_pop)
         begin
            if (v1_ff)
            begin
               d0_ff <= d1_ff;
               q0_ff <= q1_ff;
               v1_ff <= 1'b0;
            end
            else
            begin
               v0_ff <= 1'b0;
            end
         end
         if (pop_en)
         begin
            if (!v0_ff || (out_pop && !v1_ff))
            begin
               d0_ff <= head_frame[pick];
               q0_ff <= pick;
               v0_ff <= 1'b1;
            end
            else
            begin
               d1_ff <= head_frame[pick];
               q1_ff <= pick;
               v1_ff <= 1'b1;
            end
         end
      end
   end

   // ahb-lite slave
   assign ap_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && (hsize_i == HSIZE_WORD);

   always_comb
   begin
      case (haddr_i[7:0])
         ADDR_CTRL: rd_mux = {30'h0000_0000, mode_ff};
         ADDR_WEIGHT: rd_mux = weight_ff;
         ADDR_MAP: rd_mux = {16'h0000, map_ff};
         ADDR_PORT_PRIO: rd_mux = port_prio_ff;
         ADDR_STATUS: rd_mux = {16'h0000, q_cnt[3], q_cnt[2], q_cnt[1], q_cnt[0]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hreadyout_ff <= 1'b1;
         hrdata_ff <= '0;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= '0;
      end
      else
      begin
         hreadyout_ff <= 1'b1;
         if (hready_i)
         begin
            wr_pend_ff <= ap_ok && hwrite_i;
            wr_addr_ff <= haddr_i[7:0];
            if (ap_ok && !hwrite_i)
            begin
               hrdata_ff <= rd_mux;
            end
         end
      end
   end

   // configuration registers, written in the data phase
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode_ff <= RST_MODE;
         weight_ff <= RST_WEIGHT;
         map_ff <= RST_MAP;
         port_prio_ff <= RST_PORT_PRIO;
      end
      else if (wr_pend_ff)
      begin
         case (wr_addr_ff)
            ADDR_CTRL: mode_ff <= hwdata_i[1:0];
            ADDR_WEIGHT: weight_ff <= hwdata_i;
            ADDR_MAP: map_ff <= hwdata_i[MAP_W-1:0];
            ADDR_PORT_PRIO: port_prio_ff <= hwdata_i;
            ADDR_PORT_SET:
            begin
               for (int p = 0; p < PORTS; p++)
               begin
                  if (hwdata_i[PSET_MASK_LSB + p])
                  begin
                     port_prio_ff[p*PCFG_W +: PCFG_W] <=
                        {hwdata_i[PSET_EN_BIT], hwdata_i[PRIO_W-1:0]};
                  end
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   assign hreadyout_o = hreadyout_ff;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_ff;
   assign rx_ready_o = rx_ready_ff;
   assign tx_valid_o = v0_ff;
   assign tx_frame_o = d0_ff;
   assign tx_queue_o = q0_ff;

endmodule
`default_nettype wire

// *** tb/qps_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module qps_chk (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic hsel_i, // select
   input wire logic [31:0] haddr_i, // address
   input wire logic [1:0] htrans_i, // transfer type
   input wire logic hwrite_i, // write
   input wire logic [2:0] hsize_i, // size
   input wire logic hready_i, // bus ready
   input wire logic hreadyout_o, // slave ready
   input wire logic hresp_o, // response
   input wire logic [31:0] hrdata_o, // read data
   input wire logic rx_valid_i, // offered
   input wire logic rx_ready_o, // accepted
   input wire logic tx_valid_o, // ready to send
   input wire logic tx_ready_i, // taken
   input wire logic [qps_pkg::FRAME_W-1:0] tx_frame_o, // handle
   input wire logic [qps_pkg::QW-1:0] tx_queue_o // queue
);
   import qps_pkg::*;
   logic [5:0] cnt_ff;
   logic up_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // frames held inside the block, queues and output buffer together
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_ff <= 6'h0;
         up_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 6'(rx_valid_i & rx_ready_o) - 6'(tx_valid_o & tx_ready_i);
         up_ff <= 1'b1;
      end
   end
   ready_high_a: assert property (hreadyout_o)
      else $error("slave not ready");
   resp_okay_a: assert property (!hresp_o)
      else $error("error response");
   tx_hold_a: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o) && $stable(tx_queue_o))
      else $error("waiting descriptor changed");
   tx_need_a: assert property (tx_valid_o |-> cnt_ff != 6'h0)
      else $error("descriptor out of nothing");
   cnt_max_a: assert property (cnt_ff <= 6'h22)
      else $error("more frames held than storage");
   rx_room_a: assert property (up_ff && cnt_ff <= 6'h6 |-> rx_ready_o)
      else $error("refused with room left");
   rx_full_a: assert property ($fell(rx_ready_o) |-> cnt_ff >= 6'h7)
      else $error("refused too early");
   fast_out_a: assert property (
      cnt_ff == 6'h0 && rx_valid_i && rx_ready_o |-> ##[1:4] tx_valid_o)
      else $error("lone frame not sent");
   rd_zero_a: assert property (
      hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i && hsize_i == HSIZE_WORD
      && (haddr_i[7:0] == ADDR_PORT_SET || haddr_i[7:0] > ADDR_STATUS) |=> hrdata_o == 32'h0)
      else $error("unreadable place gave data");
endmodule
bind qps_top qps_chk qps_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
   .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
   .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .tx_frame_o(tx_frame_o), .tx_queue_o(tx_queue_o));
`default_nettype wire

// *** tb/qps_sink.sv ***
`timescale 1ns/10ps
`default_nettype none
module qps_sink (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic [1:0] mode_i, // 0 prompt, 1 random stall, 2 hold off
   output logic ready_o // transmit side takes a frame
);
   int sd = 32'h2414_59d4;
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         ready_o <= 1'b0;
      else
         ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && $random(sd) % 2 == 0);
endmodule
`default_nettype wire

// *** tb/qps_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module qps_top_tb;
   import qps_pkg::*;
   logic clk_i = 0, rst_n_i = 0, hsel_i = 1, hwrite_i = 0, rx_valid_i = 0, rx_tagged_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o;
   logic [1:0] htrans_i = 0, tx_queue_o, smode = 2;
   logic [2:0] hsize_i = 0, rx_port_i = 0, rx_pcp_i = 0;
   logic [7:0] rx_frame_i = 0, tx_frame_o;
   logic hreadyout_o, hresp_o, rx_ready_o, tx_valid_o, tx_ready_i;
   logic [31:0] wgt = RST_WEIGHT, pp = RST_PORT_PRIO;
   logic [15:0] map = RST_MAP;
   logic [9:0] exq[$], arr[$], pq[4][$];
   int n_mismatch = 0, checked = 0, cyc = 0, seed = 32'h2414_59d4;
   always #5 clk_i = ~clk_i;
   qps_top qps_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
      .rx_frame_i(rx_frame_i), .rx_port_i(rx_port_i), .rx_tagged_i(rx_tagged_i),
      .rx_pcp_i(rx_pcp_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .tx_frame_o(tx_frame_o), .tx_queue_o(tx_queue_o));
   qps_sink qps_sink_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(smode), .ready_o(tx_ready_i));
   task automatic stop_test();
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   // each frame taken by the sink is checked against the oldest expected one
   always @(posedge clk_i)
      if (rst_n_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      begin
         if (exq.size() == 0)
            chk({22'h0, tx_frame_o, tx_queue_o}, 32'hffff_ffff);
         else
            chk({22'h0, tx_frame_o, tx_queue_o}, {22'h0, exq.pop_front()});
      end
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      htrans_i <= HTRANS_NONSEQ;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      hsize_i <= HSIZE_WORD;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask
   task automatic push(input logic t, input logic [2:0] pt, input logic [2:0] pc);
      logic [7:0] f;
      logic [2:0] p;
      f = 8'($random(seed));
      p = t ? pc : (pp[4*pt+3] ? pp[4*pt+:3] : 3'h0);
      rx_valid_i <= 1'b1;
      rx_frame_i <= f;
      rx_port_i <= pt;
      rx_tagged_i <= t;
      rx_pcp_i <= pc;
      do @(posedge clk_i); while (rx_ready_o !== 1'b1);
      arr.push_back({f, map[2*p+:2]});
   endtask
   // load with the sink held off, then drain; the first two frames sit in the output buffer
   task automatic batch(input logic [1:0] md, input int kind, input int n, input logic [1:0] dm);
      int cur, cn, j;
      logic [15:0] occ;
      smode <= 2'h2;
      wr(ADDR_CTRL, {30'h0, md});
      arr.delete();
      for (int i = 0; i < n + 2; i++)
      begin
         j = i - 2;
         if (i < 2)
            push(1'b1, 3'($random(seed)), 3'h0);
         else if (kind == 1 && j[0])
            push(1'b0, 3'(j >> 1), 3'($random(seed)));
         else
            push(1'b1, 3'($random(seed)), 3'(kind == 2 ? 7 : j));
      end
      rx_valid_i <= 1'b0;
      for (int q = 0; q < 4; q++)
         pq[q].delete();
      exq.push_back(arr.pop_front());
      exq.push_back(arr.pop_front());
      foreach (arr[k])
         pq[arr[k][1:0]].push_back(arr[k]);
      // queue occupancy while loaded, the two buffered frames excluded
      occ = {4'(pq[3].size()), 4'(pq[2].size()), 4'(pq[1].size()), 4'(pq[0].size())};
      rdc(ADDR_STATUS, {16'h0, occ});
      if (kind == 2)
         chk({31'h0, rx_ready_o}, 32'h0);
      cur = 0;
      cn = 0;
      if (md < MODE_STRICT)
         exq = {exq, arr};
      else
         while (pq[0].size() + pq[1].size() + pq[2].size() + pq[3].size() > 0)
            if (pq[cur].size() == 0)
            begin
               cur = (cur + 1) % 4;
               cn = 0;
            end
            else
            begin
               exq.push_back(pq[cur].pop_front());
               cn++;
               if (md == MODE_STRICT)
                  cur = 0;
               else if (cn >= int'(wgt[8*cur+:8]))
               begin
                  cur = (cur + 1) % 4;
                  cn = 0;
               end
            end
      smode <= dm;
      while (exq.size() > 0)
         @(posedge clk_i);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rdc(ADDR_CTRL, 32'h0000_0003);
      rdc(ADDR_WEIGHT, 32'h0102_0408);
      rdc(ADDR_MAP, 32'h0000_05af);
      rdc(ADDR_PORT_PRIO, 32'h0000_0000);
      rdc(8'h18, 32'h0000_0000);
      batch(MODE_WRR, 0, 16, 2'h1);
      batch(MODE_STRICT, 0, 16, 2'h0);
      batch(MODE_FCFS, 0, 16, 2'h1);
      batch(MODE_OFF, 0, 16, 2'h0);
      batch(MODE_WRR, 2, 8, 2'h1);
      wr(ADDR_PORT_SET, 32'h0000_0f16);
      wr(ADDR_PORT_SET, 32'h0000_3013);
      pp = 32'h00bb_eeee;
      rdc(ADDR_PORT_PRIO, pp);
      rdc(ADDR_PORT_SET, 32'h0000_0000);
      batch(MODE_FCFS, 1, 16, 2'h1);
      wr(ADDR_PORT_SET, 32'h0000_0100);
      rdc(ADDR_PORT_PRIO, 32'h00bb_eee0);
      wgt = 32'h0101_0203;
      map = 16'h1b1b;
      wr(ADDR_WEIGHT, wgt);
      wr(ADDR_MAP, {16'h0, map});
      rdc(ADDR_WEIGHT, wgt);
      rdc(ADDR_MAP, {16'h0, map});
      batch(MODE_WRR, 0, 16, 2'h1);
      stop_test();
   end
endmodule
`default_nettype wire
